// ### shared/i2c_port_pkg.sv
`default_nettype none

package i2c_port_pkg;

  // ************************************************************
  // Bus addressing
  // ************************************************************
  localparam logic [6:0] TARGET_ADDR = 7'h31;
  localparam logic [7:0] REG_FIRST = 8'h00;
  localparam logic [7:0] REG_LAST = 8'h0E;
  localparam logic [7:0] REG_CHIP_ID = 8'h00;
  localparam logic [7:0] REG_SOFT_RESET = 8'h0E;
  localparam int REG_COUNT = 15;

  // Identity byte: value is arbitrary
  localparam logic [7:0] CHIP_ID_VALUE = 8'hA5;

  // ************************************************************
  // Register bank defaults, entry i in bits [8*i+7:8*i]
  // ************************************************************
  localparam logic [8*REG_COUNT-1:0] REG_DEFAULT = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h35, 8'h10, 8'h00
  };

  // ************************************************************
  // Framing and buffering
  // ************************************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int WRITE_FIFO_DEPTH = 8;

  // One accepted register write on its way to the converter
  typedef struct packed {
    logic [7:0] reg_addr;
    logic [7:0] data;
  } cfg_write_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} bus_state_t;
  typedef enum logic [1:0] {KIND_ADDR, KIND_REG, KIND_DATA} byte_kind_t;

endpackage

`default_nettype wire

// ### verification/i2c_host_model.sv
`default_nettype none

module i2c_host_model (
  // Clock and lines
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  // Open-drain pulls and wait flag
  output var logic scl_low,
  output var logic sda_low,
  output var logic hung
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Bus controller
  // ********
  // Lines released at time zero, bus free
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hung = 1'b0;
  end

  // Half of a 160 ns bit period, stepped on falling clock edges
  task automatic half();
    repeat (8) @(negedge clock);
  endtask

  // One clock pulse; data set only while scl is low
  task automatic bit_io(input logic b, output logic r);
    int n;
    // One clock after scl falls, so sda never moves with the clock edge
    @(negedge clock);
    sda_low = !b;
    half();
    scl_low = 1'b0;
    n = 0;
    // The target may hold scl low; wait, but not for ever
    while (!scl && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000) hung = 1'b1;
    half();
    r = sda;
    scl_low = 1'b1;
  endtask

  // Falling sda with scl high, then scl low
  task automatic start();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask

  task automatic restart();
    @(negedge clock);
    sda_low = 1'b0;
    half();
    scl_low = 1'b0;
    half();
    start();
  endtask

  // Rising sda with scl high frees the bus
  task automatic stop();
    @(negedge clock);
    sda_low = 1'b1;
    half();
    scl_low = 1'b0;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // Eight bits MSB first, then sda released for the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Acknowledge asks for more; the last byte is left unacknowledged
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // i2c_host_model

`default_nettype wire

// ### verification/i2c_port_asserts.sv
`default_nettype none

module i2c_port_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Write stream
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  input wire i2c_port_pkg::cfg_write_t cfg,
  input wire logic soft_reset
);
  // ********
  // Line and stream properties
  // ********
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // A pop of a write to the bank-clear register
  wire pop_clear = cfg_valid && cfg_ready && cfg.reg_addr == i2c_port_pkg::REG_SOFT_RESET;

  scl_open_drain_a: assert property (scl_out == 1'b0)
    else $error("scl output value not low");
  sda_open_drain_a: assert property (sda_out == 1'b0)
    else $error("sda output value not low");
  sda_low_change_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda pull changed while scl high");
  stretch_on_low_a: assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("clock stretch started while scl high");
  stretch_when_full_a: assert property (scl_oe |-> cfg_valid)
    else $error("clock stretched with empty buffer");
  cfg_hold_a: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg))
    else $error("write word changed before taken");
  cfg_range_a: assert property (cfg_valid |-> cfg.reg_addr <= i2c_port_pkg::REG_LAST)
    else $error("write to undefined register");
  clear_pulse_a: assert property (pop_clear |=> soft_reset)
    else $error("bank clear missing after pop");
  clear_cause_a: assert property (soft_reset |-> $past(pop_clear))
    else $error("bank clear without pop");

  // Main scenarios reached
  cover property (scl_oe);
  cover property (cfg_valid && cfg_ready);
  cover property (soft_reset);
  cover property (sda_oe && !sda_in && scl_in);
endmodule // i2c_port_asserts

bind i2c_register_slave_port i2c_port_asserts chk (.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg(cfg), .soft_reset(soft_reset));

`default_nettype wire

// ### verification/i2c_register_slave_port_test.sv
`default_nettype none

module i2c_register_slave_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Bench signals
  // ********
  logic clock, sys_rst, cfg_ready, stall, saw_stretch;
  wire logic scl_out, scl_oe, sda_out, sda_oe, cfg_valid, soft_reset, scl_low, sda_low, hung;
  wire i2c_port_pkg::cfg_write_t cfg;
  int n_mismatch, n_tests, n_clear;
  logic [31:0] seed;
  logic [7:0] mem [0:15];
  i2c_port_pkg::cfg_write_t exp_q [$];
  // Pull-ups: a line is low while any party pulls it
  wire logic scl = !(scl_low || scl_oe);
  wire logic sda = !(sda_low || sda_oe);

  i2c_register_slave_port uut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg(cfg), .soft_reset(soft_reset));
  i2c_host_model host (.clock(clock), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low),
    .hung(hung));

  always #5 clock = ~clock;

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task finish_test;
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Expected bank after reset; the identity byte reads at 00h
  task automatic defaults();
    for (int i = 0; i < 15; i++) mem[i] = i2c_port_pkg::REG_DEFAULT[8*i +: 8];
    mem[0] = i2c_port_pkg::CHIP_ID_VALUE;
    mem[14] = 8'h00;
    mem[15] = 8'h00;
  endtask

  // Register write of n random bytes; acks expected only inside the bank
  task automatic wr(input logic [7:0] ra, input int n);
    logic a, ok;
    logic [7:0] d;
    host.start();
    host.wbyte({i2c_port_pkg::TARGET_ADDR, 1'b0}, a);
    check({15'h0000, a}, 16'h0001);
    host.wbyte(ra, a);
    ok = ra <= i2c_port_pkg::REG_LAST;
    check({15'h0000, a}, {15'h0000, ok});
    // No data after a refusal; each note goes in before its byte can leave the buffer
    for (int k = 0; k < n && ok; k++) begin
      d = 8'(rnd());
      ok = ok && ra + k <= 14;
      if (ok) begin
        exp_q.push_back({ra + k[7:0], d});
        mem[ra + k] = d;
        if (ra + k == 14) defaults();
      end
      host.wbyte(d, a);
      check({15'h0000, a}, {15'h0000, ok});
    end
    host.stop();
  endtask

  // Set pointer, repeated start, read n bytes
  task automatic rd(input logic [7:0] ra, input int n);
    logic a;
    logic [7:0] d;
    host.start();
    host.wbyte({i2c_port_pkg::TARGET_ADDR, 1'b0}, a);
    host.wbyte(ra, a);
    host.restart();
    host.wbyte({i2c_port_pkg::TARGET_ADDR, 1'b1}, a);
    check({15'h0000, a}, 16'h0001);
    for (int k = 0; k < n; k++) begin
      host.rbyte(k < n - 1, d);
      check({8'h00, d}, {8'h00, mem[ra + k]});
    end
    host.stop();
  endtask

  // Wait until every noted write has left the buffer
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() > 0 || cfg_valid !== 1'b0) && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // ********
  // Stream side and result watcher
  // ********
  // Random taking, held off while stalling; a stretch ends the stall
  always @(negedge clock) begin
    cfg_ready <= !stall && rnd() > 32'h7FFFFFFF;
    if (scl_oe === 1'b1) begin
      saw_stretch <= 1'b1;
      stall <= 1'b0;
    end
  end

  // Each accepted word is matched with the oldest note; bank clears are counted
  always @(posedge clock) begin
    if (soft_reset === 1'b1) n_clear++;
    if (cfg_valid === 1'b1 && cfg_ready) begin
      if (exp_q.size() == 0) check(cfg, 16'hXXXX);
      else check(cfg, exp_q.pop_front());
    end
  end

  always @(posedge hung) begin
    n_mismatch++;
    finish_test();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    logic a;
    clock = 1'b0;
    sys_rst = 1'b1;
    cfg_ready = 1'b0;
    stall = 1'b0;
    saw_stretch = 1'b0;
    seed = 32'hF434B1B8;
    n_mismatch = 0;
    n_tests = 0;
    n_clear = 0;
    defaults();
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    rd(8'h00, 4);
    // Another target address is ignored
    host.start();
    host.wbyte({7'h30, 1'b0}, a);
    check({15'h0000, a}, 16'h0000);
    host.stop();
    // Ten bytes against a stalled stream overflow the buffer of eight
    stall = 1'b1;
    wr(8'h03, 10);
    check({15'h0000, saw_stretch}, 16'h0001);
    drain();
    rd(8'h03, 12);
    wr(8'h0F, 1);
    // Clear register in mid-run, then one byte past the bank
    wr(8'h0D, 3);
    drain();
    rd(8'h01, 3);
    // Exactly one bank clear was announced
    check(n_clear[15:0], 16'h0001);
    finish_test();
  end
endmodule // i2c_register_slave_port_test

`default_nettype wire

// ### verilog/i2c_register_slave_port.sv
// Behaviour
// - Target only, own address 31h
// - Registers 01h through 0Dh readable and writable, 00h read-only
// - Works at 100 and 400 kbit/s
// - Data changes only while clock low
// - Detect start and stop with clock high
// - Eight-bit bytes, each followed by acknowledge
// - Most significant bit first
// - Unlimited bytes per transfer; written bytes acknowledged only up to 0Eh
// - Device may stretch clock when not ready
// - Receiver holds data low through acknowledge
// - First byte: address plus direction bit
// - Write: address, register, data, each acknowledged
// - Undefined register address: not-acknowledge, go idle
// - Multi-byte reads and writes supported
// - Write to 0Eh resets bank, write-only

`default_nettype none

module i2c_register_slave_port (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Accepted register writes toward the converter
  output logic cfg_valid,
  input wire logic cfg_ready,
  output i2c_port_pkg::cfg_write_t cfg,
  // Bank returned to defaults
  output logic soft_reset
);

  // ************************************************************
  // Line sampling
  // ************************************************************

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;

  // Three flops per line; at 10 ns a 400 kbit/s bit is well oversampled
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  // Edge and condition decode, from the second and third flops
  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;
  wire scl_high = scl && scl_q;
  wire start_seen = scl_high && sda_q && !sda;
  wire stop_seen = scl_high && !sda_q && sda;

  // ************************************************************
  // Protocol state
  // ************************************************************

  i2c_port_pkg::bus_state_t state;
  i2c_port_pkg::bus_state_t next_state;
  i2c_port_pkg::byte_kind_t kind;
  i2c_port_pkg::byte_kind_t next_kind;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  logic read_dir;
  logic next_read_dir;
  logic more;
  logic next_more;
  logic stretch;
  logic next_stretch;
  logic drive_low;
  logic next_drive_low;

  logic [7:0] rd_data;
  logic push_ready;
  logic fifo_valid;
  i2c_port_pkg::cfg_write_t fifo_data;

  // Byte boundary: eighth bit taken and clock gone low, or held low by us
  wire in_rx = (state == i2c_port_pkg::ST_RX);
  wire byte_end = in_rx && (bitcnt == i2c_port_pkg::BITS_PER_BYTE) && (scl_fall || stretch);
  wire addr_hit = (shift[7:1] == i2c_port_pkg::TARGET_ADDR);
  wire reg_ok = (shift <= i2c_port_pkg::REG_LAST);
  wire ptr_ok = (pointer <= i2c_port_pkg::REG_LAST);
  wire is_data = (kind == i2c_port_pkg::KIND_DATA);
  wire push_valid = byte_end && is_data && ptr_ok;
  wire [7:0] pointer_inc = 8'(pointer + 8'h01);

  // Next-state logic; start and stop override whatever byte is in flight
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_shift = shift;
    next_bitcnt = bitcnt;
    next_pointer = pointer;
    next_read_dir = read_dir;
    next_more = more;
    next_stretch = stretch;
    next_drive_low = drive_low;
    if (start_seen) begin
      // A repeated start lands here too and keeps the pointer
      next_state = i2c_port_pkg::ST_RX;
      next_kind = i2c_port_pkg::KIND_ADDR;
      next_bitcnt = 4'h0;
      next_drive_low = 1'b0;
      next_stretch = 1'b0;
    end else if (stop_seen) begin
      next_state = i2c_port_pkg::ST_IDLE;
      next_drive_low = 1'b0;
      next_stretch = 1'b0;
    end else begin
      case (state)
        i2c_port_pkg::ST_RX: begin
          if (scl_rise && bitcnt != i2c_port_pkg::BITS_PER_BYTE) begin
            next_shift = {shift[6:0], sda};
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (byte_end) begin
            case (kind)
              i2c_port_pkg::KIND_ADDR: begin
                if (addr_hit) begin
                  next_read_dir = shift[0];
                  next_state = i2c_port_pkg::ST_ACK;
                  next_drive_low = 1'b1;
                end else begin
                  next_state = i2c_port_pkg::ST_IDLE;
                end
              end
              i2c_port_pkg::KIND_REG: begin
                if (reg_ok) begin
                  next_pointer = shift;
                  next_state = i2c_port_pkg::ST_ACK;
                  next_drive_low = 1'b1;
                end else begin
                  next_state = i2c_port_pkg::ST_IDLE;
                end
              end
              default: begin
                if (!ptr_ok) begin
                  // Pointer ran off the bank: refuse the byte
                  next_state = i2c_port_pkg::ST_IDLE;
                  next_stretch = 1'b0;
                end else if (push_ready) begin
                  // Stretch stays on for now; the ack state lets go of scl
                  next_pointer = pointer_inc;
                  next_state = i2c_port_pkg::ST_ACK;
                  next_drive_low = 1'b1;
                end else begin
                  // Buffer full: hold the clock low until one entry is taken from it
                  next_stretch = 1'b1;
                end
              end
            endcase
          end
        end
        i2c_port_pkg::ST_ACK: begin
          // Release scl a cycle after sda is pulled, so sda never moves with scl high
          next_stretch = 1'b0;
          if (scl_fall) begin
            // Let go of the line only after the ninth pulse ends
            next_drive_low = 1'b0;
            next_bitcnt = 4'h0;
            if (kind == i2c_port_pkg::KIND_ADDR && read_dir) begin
              next_state = i2c_port_pkg::ST_TX;
              next_shift = rd_data;
              next_drive_low = !rd_data[7];
            end else begin
              next_state = i2c_port_pkg::ST_RX;
              next_kind = (kind == i2c_port_pkg::KIND_ADDR) ? i2c_port_pkg::KIND_REG : i2c_port_pkg::KIND_DATA;
            end
          end
        end
        i2c_port_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              // Eighth bit done: release for the controller's answer
              next_state = i2c_port_pkg::ST_MACK;
              next_drive_low = 1'b0;
              next_pointer = pointer_inc;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_drive_low = !shift[6];
              next_bitcnt = 4'(bitcnt + 4'h1);
            end
          end
        end
        i2c_port_pkg::ST_MACK: begin
          if (scl_rise) begin
            next_more = !sda;
          end else if (scl_fall) begin
            if (more) begin
              // Controller wants another byte
              next_state = i2c_port_pkg::ST_TX;
              next_shift = rd_data;
              next_drive_low = !rd_data[7];
              next_bitcnt = 4'h0;
            end else begin
              // Not acknowledged: wait for stop or restart
              next_state = i2c_port_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_state = i2c_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= i2c_port_pkg::ST_IDLE;
      kind <= i2c_port_pkg::KIND_ADDR;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      pointer <= 8'h00;
      read_dir <= 1'b0;
      more <= 1'b0;
      stretch <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      shift <= next_shift;
      bitcnt <= next_bitcnt;
      pointer <= next_pointer;
      read_dir <= next_read_dir;
      more <= next_more;
      stretch <= next_stretch;
      drive_low <= next_drive_low;
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************

  // Open drain: only ever pull low, release means enable off
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign scl_out = 1'b0;
  assign scl_oe = stretch;

  // ************************************************************
  // Write buffer and register bank
  // ************************************************************

  i2c_port_pkg::cfg_write_t push_data;
  assign push_data.reg_addr = pointer;
  assign push_data.data = shift;

  write_fifo #(
    .WIDTH($bits(i2c_port_pkg::cfg_write_t)),
    .DEPTH(i2c_port_pkg::WRITE_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(cfg_ready),
    .out_data(fifo_data)
  );

  // The bank changes only when the converter side takes the write
  wire pop = fifo_valid && cfg_ready;
  wire pop_reset = pop && (fifo_data.reg_addr == i2c_port_pkg::REG_SOFT_RESET);
  wire pop_write = pop && !pop_reset && (fifo_data.reg_addr != i2c_port_pkg::REG_CHIP_ID);
  assign cfg_valid = fifo_valid;
  assign cfg = fifo_data;

  reg_bank_mem u_bank (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(pop_write),
    .wr_addr(fifo_data.reg_addr),
    .wr_data(fifo_data.data),
    .clear(pop_reset),
    .rd_addr(pointer),
    .rd_data(rd_data)
  );

  // One-cycle notice that the bank went back to defaults
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= pop_reset;
    end
  end

endmodule // i2c_register_slave_port

`default_nettype wire

// ### verilog/reg_bank_mem.sv
`default_nettype none

module reg_bank_mem (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Write port and bank clear
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic clear,
  // Registered read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] entry [i2c_port_pkg::REG_COUNT];

  // Entry 0 is the fixed identity byte, the rest are writable flops
  assign entry[0] = i2c_port_pkg::CHIP_ID_VALUE;

  genvar i;
  generate
    for (i = 1; i < i2c_port_pkg::REG_COUNT; i++) begin : g_entry
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          entry[i] <= i2c_port_pkg::REG_DEFAULT[8*i +: 8];
        end else if (clear) begin
          entry[i] <= i2c_port_pkg::REG_DEFAULT[8*i +: 8];
        end else if (wr_en && wr_addr == 8'(i)) begin
          entry[i] <= wr_data;
        end
      end
    end
  endgenerate

  // Unmapped and write-only locations read as zero
  wire rd_ok = (rd_addr <= i2c_port_pkg::REG_LAST) && (rd_addr != i2c_port_pkg::REG_SOFT_RESET);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_ok ? entry[rd_addr[3:0]] : 8'h00;
    end
  end

endmodule // reg_bank_mem

`default_nettype wire

// ### verilog/write_fifo.sv
`default_nettype none

module write_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];

  // Storage has no reset; only pointers and count are control state
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

endmodule // write_fifo

`default_nettype wire
